// >>> design/scg_cfg.svh
/*
  Offsets, field layout, reset values and derived masks of the
  sleep-mode unit clock gating block.
  Assumes it is included by bare name wherever offsets are needed.
*/
`ifndef SCG_CFG_SVH
`define SCG_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCG_BASE_ADDR       32'h400f_e000
`define SCG_OFS_RUN_CFG     12'h060
`define SCG_OFS_RUN_GATE    12'h104
`define SCG_OFS_SLEEP_GATE  12'h114
`define SCG_OFS_DEEP_GATE   12'h124
`define SCG_OFS_INT_STATUS  12'h200
`define SCG_OFS_INT_MASK    12'h204

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define SCG_BIT_GP_COUNTER2_CLOCK_GATE      18
`define SCG_BIT_GP_COUNTER1_CLOCK_GATE      17
`define SCG_BIT_GP_COUNTER0_CLOCK_GATE      16
`define SCG_BIT_TWO_WIRE0   12
`define SCG_BIT_SYNC0       4
`define SCG_BIT_ASYNC1      1
`define SCG_BIT_ASYNC0      0
`define SCG_GATE_WMASK      32'h0007_1013
`define SCG_BIT_AUTO_GATE   27
`define SCG_RUN_CFG_WMASK   32'h0800_0000

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCG_GATE_RESET      32'h0000_0000
`define SCG_RUN_CFG_RESET   32'h0000_0000
`define SCG_INT_RESET       32'h0000_0000

`endif

// >>> design/scg_gate_ctrl.sv
/*
  Unit clock gating control: run, sleep and deep-sleep gate registers,
  run clock configuration with the auto gating bit, per-unit clock
  enables, bus fault on access to a gated unit and a fault interrupt.
  Assumes a single clock, synchronous inputs, and that the system
  decode flags each peripheral access on unit_access for one cycle.
*/
`default_nettype none

`include "scg_cfg.svh"

module scg_gate_ctrl
  import scg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire scg_req_s    req,
  output logic      [31:0] rdata,
  input  wire logic        sleep_req,
  input  wire logic        deep_sleep_req,
  input  wire scg_gate_s   unit_access,
  output scg_gate_s        unit_clk_en,
  output logic             bus_fault,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Writable gate bits take the new data, reserved bits stay zero
  function automatic scg_gate_s gate_wr(input logic [31:0] wdata);
    gate_wr = scg_gate_s'(wdata & `SCG_GATE_WMASK);
  endfunction

  // Offset match for a given strobe
  function automatic logic hit(input logic strobe, input logic [11:0] a,
                               input logic [11:0] ofs);
    hit = strobe && (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  scg_gate_s   run_gate_ff;
  scg_gate_s   sleep_gate_ff;
  scg_gate_s   deep_gate_ff;
  logic        auto_gate_ff;
  scg_gate_s   int_status_ff;
  scg_gate_s   int_mask_ff;
  scg_mode_e   mode_ff;
  scg_gate_s   clk_en_ff;
  logic        bus_fault_ff;
  logic        irq_ff;
  logic [31:0] rdata_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic wr_run    = hit(req.wr, req.addr, `SCG_OFS_RUN_GATE);
  wire logic wr_sleep  = hit(req.wr, req.addr, `SCG_OFS_SLEEP_GATE);
  wire logic wr_deep   = hit(req.wr, req.addr, `SCG_OFS_DEEP_GATE);
  wire logic wr_cfg    = hit(req.wr, req.addr, `SCG_OFS_RUN_CFG);
  wire logic wr_status = hit(req.wr, req.addr, `SCG_OFS_INT_STATUS);
  wire logic wr_mask   = hit(req.wr, req.addr, `SCG_OFS_INT_MASK);

  // Auto gating bit placed in the run clock configuration word
  wire logic [31:0] cfg_word = {4'h0, auto_gate_ff, 27'h0};

  // Read mux; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (req.addr)
      `SCG_OFS_RUN_GATE:   rd_mux = run_gate_ff;
      `SCG_OFS_SLEEP_GATE: rd_mux = sleep_gate_ff;
      `SCG_OFS_DEEP_GATE:  rd_mux = deep_gate_ff;
      `SCG_OFS_RUN_CFG:    rd_mux = cfg_word;
      `SCG_OFS_INT_STATUS: rd_mux = int_status_ff;
      `SCG_OFS_INT_MASK:   rd_mux = int_mask_ff;
      default:             rd_mux = 32'h0000_0000;
    endcase
  end
  wire logic [31:0] nxt_rdata = req.rd ? rd_mux : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Gate selection
  // ----------------------------------------------------------------

  // Mode follows the sleep controller's request levels
  scg_mode_e nxt_mode;
  always_comb begin
    if (deep_sleep_req) begin
      nxt_mode = SCG_MODE_DEEP;
    end else if (sleep_req) begin
      nxt_mode = SCG_MODE_SLEEP;
    end else begin
      nxt_mode = SCG_MODE_RUN;
    end
  end

  // Pick the register that drives the unit enables
  scg_gate_s sel_gate;
  always_comb begin
    case (mode_ff)
      SCG_MODE_RUN:   sel_gate = run_gate_ff;
      SCG_MODE_SLEEP: sel_gate = auto_gate_ff ? sleep_gate_ff : run_gate_ff;
      SCG_MODE_DEEP:  sel_gate = auto_gate_ff ? deep_gate_ff : run_gate_ff;
      default:        sel_gate = run_gate_ff;
    endcase
  end
  wire scg_gate_s nxt_clk_en = scg_gate_s'(sel_gate & `SCG_GATE_WMASK);

  // ----------------------------------------------------------------
  // Fault and interrupt
  // ----------------------------------------------------------------

  // Access to a unit that is not clocked
  wire scg_gate_s fault_set = scg_gate_s'(unit_access & ~clk_en_ff
                                          & `SCG_GATE_WMASK);
  // Write one to clear; a new fault wins over the clear
  wire scg_gate_s st_clr    = wr_status ? scg_gate_s'(req.wdata) : '0;
  wire scg_gate_s nxt_status = scg_gate_s'((int_status_ff & ~st_clr) | fault_set);
  wire logic      nxt_irq    = |(nxt_status & int_mask_ff);

  // ----------------------------------------------------------------
  // Gate and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_gate_ff   <= scg_gate_s'(`SCG_GATE_RESET);
      sleep_gate_ff <= scg_gate_s'(`SCG_GATE_RESET);
      deep_gate_ff  <= scg_gate_s'(`SCG_GATE_RESET);
      auto_gate_ff  <= 1'b0;
    end else begin
      if (wr_run) run_gate_ff <= gate_wr(req.wdata);
      if (wr_sleep) sleep_gate_ff <= gate_wr(req.wdata);
      if (wr_deep) deep_gate_ff <= gate_wr(req.wdata);
      if (wr_cfg) auto_gate_ff <= req.wdata[`SCG_BIT_AUTO_GATE];
    end
  end

  // ----------------------------------------------------------------
  // Mode, enables, interrupt and read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_ff       <= SCG_MODE_RUN;
      clk_en_ff     <= scg_gate_s'(`SCG_GATE_RESET);
      int_status_ff <= scg_gate_s'(`SCG_INT_RESET);
      int_mask_ff   <= scg_gate_s'(`SCG_INT_RESET);
      bus_fault_ff  <= 1'b0;
      irq_ff        <= 1'b0;
      rdata_ff      <= 32'h0000_0000;
    end else begin
      mode_ff       <= nxt_mode;
      clk_en_ff     <= nxt_clk_en;
      int_status_ff <= nxt_status;
      if (wr_mask) int_mask_ff <= gate_wr(req.wdata);
      bus_fault_ff  <= |fault_set;
      irq_ff        <= nxt_irq;
      rdata_ff      <= nxt_rdata;
    end
  end

  assign unit_clk_en = clk_en_ff;
  assign bus_fault   = bus_fault_ff;
  assign irq         = irq_ff;
  assign rdata       = rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_EN_FOLLOWS_GATE: assert property (@(posedge clk) disable iff (reset)
    (mode_ff == SCG_MODE_SLEEP && auto_gate_ff) |=> unit_clk_en == $past(sleep_gate_ff))
    else $error("Unit enables do not follow the sleep gate register");

  AST_FAULT_ON_GATED: assert property (@(posedge clk) disable iff (reset)
    (unit_access.gp_counter_clock_gate[0] && !unit_clk_en.gp_counter_clock_gate[0])
    |=> bus_fault && int_status_ff.gp_counter_clock_gate[0])
    else $error("Access to a gated unit raised no bus fault");

  AST_NO_FAULT_ON_OPEN: assert property (@(posedge clk) disable iff (reset)
    ((unit_access & ~unit_clk_en) == '0) |=> !bus_fault)
    else $error("Bus fault raised for a clocked unit");

  AST_RESET_CLEAR: assert property (@(posedge clk)
    $fell(reset) |-> (sleep_gate_ff == '0 && unit_clk_en == '0))
    else $error("Gate register not clear after reset");

  AST_DEEP_SEPARATE: assert property (@(posedge clk) disable iff (reset)
    (mode_ff == SCG_MODE_DEEP && auto_gate_ff) |=> unit_clk_en == $past(deep_gate_ff))
    else $error("Deep-sleep enables do not follow their own register");

  AST_NO_AUTO_RUN: assert property (@(posedge clk) disable iff (reset)
    (!auto_gate_ff || mode_ff == SCG_MODE_RUN) |=> unit_clk_en == $past(run_gate_ff))
    else $error("Enables left the run register without auto gating");

  AST_WRITE_FIELDS: assert property (@(posedge clk) disable iff (reset)
    wr_sleep |=> sleep_gate_ff.gp_counter_clock_gate == $past(req.wdata[18:16])
                 && sleep_gate_ff.two_wire_port0_clock_gate == $past(req.wdata[12])
                 && sleep_gate_ff.sync_serial0_clock_gate == $past(req.wdata[4])
                 && sleep_gate_ff.async_serial_clock_gate == $past(req.wdata[1:0]))
    else $error("Sleep gate fields did not take the written value");

  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (reset)
    (sleep_gate_ff & ~`SCG_GATE_WMASK) == '0)
    else $error("Reserved bit of the sleep gate register is set");

  AST_READ_SLEEP: assert property (@(posedge clk) disable iff (reset)
    (req.rd && req.addr == 12'h114) |=> rdata == $past(sleep_gate_ff))
    else $error("Read at the sleep gate offset returned wrong data");

  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (reset)
    ##1 irq == |($past(nxt_status) & $past(int_mask_ff)))
    else $error("Interrupt does not reflect masked status");

  // Mode tracking and enable layout
  AST_DEEP_WINS: assert property (@(posedge clk) disable iff (reset)
    deep_sleep_req |=> mode_ff == SCG_MODE_DEEP)
    else $error("Deep-sleep request did not take priority");

  AST_RUN_MODE_IDLE: assert property (@(posedge clk) disable iff (reset)
    (!sleep_req && !deep_sleep_req) |=> mode_ff == SCG_MODE_RUN)
    else $error("Mode left run without a sleep request");

  AST_ENABLE_RESERVED: assert property (@(posedge clk) disable iff (reset)
    (unit_clk_en & ~`SCG_GATE_WMASK) == 32'h0000_0000)
    else $error("Enable raised for a reserved bit position");

  // Register writes land with reserved bits dropped
  AST_RUN_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_run |=> run_gate_ff == scg_gate_s'($past(req.wdata) & `SCG_GATE_WMASK))
    else $error("Run gate register did not take the written value");

  AST_DEEP_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_deep |=> deep_gate_ff == scg_gate_s'($past(req.wdata) & `SCG_GATE_WMASK))
    else $error("Deep gate register did not take the written value");

  AST_CFG_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_cfg |=> auto_gate_ff == $past(req.wdata[`SCG_BIT_AUTO_GATE]))
    else $error("Auto gating bit did not take the written value");

  AST_MASK_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_mask |=> int_mask_ff == scg_gate_s'($past(req.wdata) & `SCG_GATE_WMASK))
    else $error("Interrupt mask did not take the written value");

  // Read data path
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (reset)
    !req.rd |=> rdata == 32'h0000_0000)
    else $error("Read data not zero outside a read cycle");

  AST_READ_RUN: assert property (@(posedge clk) disable iff (reset)
    (req.rd && req.addr == `SCG_OFS_RUN_GATE) |=> rdata == $past(run_gate_ff))
    else $error("Read at the run gate offset returned wrong data");

  AST_READ_DEEP: assert property (@(posedge clk) disable iff (reset)
    (req.rd && req.addr == `SCG_OFS_DEEP_GATE) |=> rdata == $past(deep_gate_ff))
    else $error("Read at the deep gate offset returned wrong data");

  AST_READ_MASK: assert property (@(posedge clk) disable iff (reset)
    (req.rd && req.addr == `SCG_OFS_INT_MASK) |=> rdata == $past(int_mask_ff))
    else $error("Read at the mask offset returned wrong data");

  AST_CFG_ONLY_AUTO: assert property (@(posedge clk) disable iff (reset)
    (req.rd && req.addr == `SCG_OFS_RUN_CFG)
    |=> (rdata & ~`SCG_RUN_CFG_WMASK) == 32'h0000_0000)
    else $error("Run clock configuration read shows more than the auto bit");

  // Sticky status, write-one-to-clear, set beats clear
  AST_STATUS_STICKY: assert property (@(posedge clk) disable iff (reset)
    !wr_status |=> (int_status_ff & $past(int_status_ff)) == $past(int_status_ff))
    else $error("Status bit dropped without a clear");

  AST_W1C_CLEARS: assert property (@(posedge clk) disable iff (reset)
    (wr_status && fault_set == '0) |=> (int_status_ff & $past(st_clr)) == '0)
    else $error("Writing one did not clear the status bit");

  AST_SET_WINS: assert property (@(posedge clk) disable iff (reset)
    (wr_status && fault_set != '0) |=> (int_status_ff & $past(fault_set)) == $past(fault_set))
    else $error("Clear beat a new fault in the same cycle");

  // Main scenarios reached
  COV_SLEEP_AUTO: cover property (@(posedge clk) disable iff (reset)
    wr_sleep ##1 (mode_ff == SCG_MODE_SLEEP && auto_gate_ff)[*2]);
  COV_FAULT: cover property (@(posedge clk) disable iff (reset) bus_fault ##1 irq);
  COV_SET_WINS: cover property (@(posedge clk) disable iff (reset)
    wr_status && (fault_set & st_clr) != '0);
  COV_DEEP_AUTO: cover property (@(posedge clk) disable iff (reset)
    (mode_ff == SCG_MODE_DEEP && auto_gate_ff)[*2]);
  COV_RMW: cover property (@(posedge clk) disable iff (reset) req.rd ##2 wr_deep);

endmodule

`default_nettype wire

// >>> design/scg_pkg.sv
/*
  Types of the sleep-mode unit clock gating block.
  Assumes scg_cfg.svh is on the include path.
*/
`default_nettype none

`include "scg_cfg.svh"

package scg_pkg;

  // ----------------------------------------------------------------
  // Gate register layout, shared by all three gate registers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [12:0] rsvd_31_19;
    logic [2:0]  gp_counter_clock_gate;
    logic [2:0]  rsvd_15_13;
    logic        two_wire_port0_clock_gate;
    logic [6:0]  rsvd_11_5;
    logic        sync_serial0_clock_gate;
    logic [1:0]  rsvd_3_2;
    logic [1:0]  async_serial_clock_gate;
  } scg_gate_s;

  // Operating mode in which gating is chosen
  typedef enum logic [1:0] {
    SCG_MODE_RUN,
    SCG_MODE_SLEEP,
    SCG_MODE_DEEP
  } scg_mode_e;

  // Register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scg_req_s;

endpackage

`default_nettype wire

// >>> dv/sleep_mode_unit_clock_gate_test.sv
/*
  Self-checking bench of the unit clock gating block: register access,
  gate selection by mode and auto gating, bus fault and its interrupt.
  Assumes scg_pkg is compiled first and scg_cfg.svh is on the include path.
*/
`default_nettype none

`include "scg_cfg.svh"

module sleep_mode_unit_clock_gate_test
  import scg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals, clock and watchdog
  // ----------------------------------------------------------------
  logic        clk;
  logic        reset;
  scg_req_s    req;
  logic [31:0] rdata;
  logic        sleep_req;
  logic        deep_sleep_req;
  scg_gate_s   unit_access;
  scg_gate_s   unit_clk_en;
  logic        bus_fault;
  logic        irq;
  int          errors;
  int          samples_checked;
  logic [31:0] rd_val;

  scg_gate_ctrl i_scg_gate_ctrl (
    .clk            (clk),
    .reset          (reset),
    .req            (req),
    .rdata          (rdata),
    .sleep_req      (sleep_req),
    .deep_sleep_req (deep_sleep_req),
    .unit_access    (unit_access),
    .unit_clk_en    (unit_clk_en),
    .bus_fault      (bus_fault),
    .irq            (irq)
  );

  // Free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cuts a hang short well inside the cycle budget
  initial begin
    #100000;
    errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [11:0] ofs, input logic [31:0] data);
    @(posedge clk);
    req <= '{addr: ofs, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [11:0] ofs);
    @(posedge clk);
    req <= '{addr: ofs, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    rd_val = rdata;
  endtask

  // Read and compare a register
  task automatic rchk(input string what, input logic [11:0] ofs, input logic [31:0] exp);
    rd(ofs);
    chk(what, exp, rd_val);
  endtask

  // Mode request levels, changed right after a rising edge
  task automatic set_mode(input logic slp, input logic deep);
    @(posedge clk);
    sleep_req      <= slp;
    deep_sleep_req <= deep;
  endtask

  // Let mode or register changes reach the enables
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // One-cycle access pulse to a unit, fault and irq seen next cycle
  task automatic poke(input logic [31:0] bits, input logic exp_fault, input logic exp_irq);
    @(posedge clk);
    unit_access <= scg_gate_s'(bits);
    @(posedge clk);
    unit_access <= scg_gate_s'(32'h0000_0000);
    #1;
    chk("bus_fault", {31'h0000_0000, exp_fault}, {31'h0000_0000, bus_fault});
    chk("irq", {31'h0000_0000, exp_irq}, {31'h0000_0000, irq});
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    samples_checked = 0;
    reset = 1'b1;
    req = '0;
    sleep_req = 1'b0;
    deep_sleep_req = 1'b0;
    unit_access = scg_gate_s'(32'h0000_0000);
    repeat (16) @(posedge clk);
    reset <= 1'b0;

    // Reset values of the three gate registers, the status register and the enables
    chk("unit_clk_en", 32'h0000_0000, unit_clk_en);
    rchk("sleep_gate", `SCG_OFS_SLEEP_GATE, 32'h0000_0000);
    rchk("run_gate", `SCG_OFS_RUN_GATE, 32'h0000_0000);
    rchk("deep_gate", `SCG_OFS_DEEP_GATE, 32'h0000_0000);
    rchk("int_status", `SCG_OFS_INT_STATUS, 32'h0000_0000);
    $display("Test reset values done");

    // Reserved bits ignore writes, gate bits keep theirs, unmapped reads 0
    wr(`SCG_OFS_SLEEP_GATE, 32'hffff_ffff);
    rchk("sleep_gate", `SCG_OFS_SLEEP_GATE, 32'h0007_1013);
    wr(`SCG_OFS_SLEEP_GATE, 32'hfff8_efec);
    rchk("sleep_gate", `SCG_OFS_SLEEP_GATE, 32'h0000_0000);
    wr(12'h118, 32'hffff_ffff);
    rchk("unmapped", 12'h118, 32'h0000_0000);
    $display("Test field layout done");

    // Three separate gate registers
    wr(`SCG_OFS_RUN_GATE, 32'h0001_0001);
    wr(`SCG_OFS_SLEEP_GATE, 32'h0006_0012);
    wr(`SCG_OFS_DEEP_GATE, 32'h0000_1010);
    rchk("run_gate", `SCG_OFS_RUN_GATE, 32'h0001_0001);
    rchk("sleep_gate", `SCG_OFS_SLEEP_GATE, 32'h0006_0012);
    rchk("deep_gate", `SCG_OFS_DEEP_GATE, 32'h0000_1010);
    // Read-modify-write keeps whatever the other bits held
    rd(`SCG_OFS_DEEP_GATE);
    wr(`SCG_OFS_DEEP_GATE, rd_val | 32'h0004_0000);
    rchk("deep_gate", `SCG_OFS_DEEP_GATE, 32'h0004_1010);
    $display("Test separate registers done");

    // Selection of enables by mode and auto gating
    set_mode(1'b1, 1'b0);
    settle();
    chk("unit_clk_en", 32'h0001_0001, unit_clk_en);
    wr(`SCG_OFS_RUN_CFG, 32'h0800_0000);
    rchk("run_cfg", `SCG_OFS_RUN_CFG, 32'h0800_0000);
    settle();
    chk("unit_clk_en", 32'h0006_0012, unit_clk_en);
    set_mode(1'b1, 1'b1);
    settle();
    chk("unit_clk_en", 32'h0004_1010, unit_clk_en);
    set_mode(1'b0, 1'b0);
    settle();
    chk("unit_clk_en", 32'h0001_0001, unit_clk_en);
    $display("Test enable selection done");

    // Fault on gated units, interrupt masking and clearing
    poke(32'h0002_0000, 1'b1, 1'b0);
    poke(32'h0001_0000, 1'b0, 1'b0);
    rchk("int_status", `SCG_OFS_INT_STATUS, 32'h0002_0000);
    wr(`SCG_OFS_INT_MASK, 32'h0007_1013);
    settle();
    chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
    wr(`SCG_OFS_INT_STATUS, 32'h0002_0000);
    settle();
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    rchk("int_status", `SCG_OFS_INT_STATUS, 32'h0000_0000);
    poke(32'h0000_1000, 1'b1, 1'b1);
    set_mode(1'b1, 1'b0);
    settle();
    poke(32'h0000_0002, 1'b0, 1'b1);
    // A fault in the cycle of its own clear keeps the status bit
    @(posedge clk);
    req         <= '{addr: `SCG_OFS_INT_STATUS, wdata: 32'h0000_1000, wr: 1'b1, rd: 1'b0};
    unit_access <= scg_gate_s'(32'h0000_1000);
    @(posedge clk);
    req.wr      <= 1'b0;
    unit_access <= scg_gate_s'(32'h0000_0000);
    rchk("int_status", `SCG_OFS_INT_STATUS, 32'h0000_1000);
    $display("Test fault and interrupt done");

    complete_run();
  end

endmodule

`default_nettype wire
